// ### hw/dirc_regs.sv
// Purpose: Identifier, power and analog input control registers of the video decoder host port.
// Assumes: One host request per cycle; the host waits for the strap capture before its first access.
// Notes:   Read data appears one cycle after the read request, marked by rdValid.
// Overview of operation
// [R1] Strap data pins into identifier low byte.
// [R2] Strap address, sync, output pins into high byte.
// [R3] Host may overwrite identifier once, first access.
// [R4] After first access identifier is read-only.
// [R5] Power state reads in two low bits.
// [R6] Code 00 full on, 11 converters off.
// [R7] Codes 01 and 10 are not implemented.
// [R8] Writing power bits changes state immediately.
// [R9] Unsupported codes keep the current power state.
// [R10] Power capability reads as zero, read-only.
// [R11] Sixteen-bit revision constant, high byte higher address.
// [R12] Source bit 1 picks channel one input.
// [R13] Source bit 0 picks channel two input.
// [R14] Video mode field selects composite or luma/chroma.
// [R15] Channel two offset control mode decode.
// [R16] Channel one offset control mode decode.
// [R17] Gain control mode decode.
// [R18] TV/VCR field selects auto, manual, forced modes.
// [R19] Unstable syncs force nonstandard handling in auto.
// [R20] Auto mode toggles filters between both value sets.
// [R21] Forced nonstandard mode filter values per standard.
// [R22] Forced standard mode filter values.
// [R23] Bit 2 holds subcarrier oscillator at nominal.
// [R24] Bit 0 enters power-down mode.
module dirc_regs (
  // Clock and reset.
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  // Host register port.
  input  wire dirc_pkg::dirc_host_req_t   hostReq,
  output      logic [7:0]                 rdData,
  output      logic                       rdValid,
  // Strap pins sampled after reset.
  input  wire dirc_pkg::dirc_strap_t      strapPins,
  // Video detection.
  input  wire logic                       palStandard,
  input  wire logic                       syncUnstable,
  // Power and oscillator control.
  output      logic                       adcOff,
  output      logic                       clockMinimum,
  output      logic                       oscFreeze,
  // Analog front end control.
  output      dirc_pkg::dirc_route_t      route,
  output      dirc_pkg::dirc_vmode_t      videoMode,
  output      dirc_pkg::dirc_ctl_mode_t   offsetModeOne,
  output      dirc_pkg::dirc_ctl_mode_t   offsetModeTwo,
  output      dirc_pkg::dirc_ctl_mode_t   gainMode,
  // Filter overrides.
  output      dirc_pkg::dirc_filter_ovr_t filterOvr,
  output      logic                       vcrActive
);

  // Both offset fields and the gain field share one encoding.
  function automatic dirc_pkg::dirc_ctl_mode_t ctlMode(input logic [1:0] code);
    ctlMode = dirc_pkg::dirc_ctl_mode_t'(code);
  endfunction

  function automatic logic hit(input logic [dirc_pkg::ADDR_W-1:0] addr, input logic [dirc_pkg::ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  dirc_pkg::dirc_strap_t strapSync1_ff;
  dirc_pkg::dirc_strap_t strapSync2_ff;
  logic [1:0]            startCnt_ff;
  logic [7:0]            idLow_ff;
  logic [7:0]            idHigh_ff;
  logic                  lockLow_ff;
  logic                  lockHigh_ff;
  dirc_pkg::dirc_pwr_t   pwr_ff;
  dirc_pkg::dirc_pwr_t   nxt_pwr;
  logic [7:0]            srcSel_ff;
  logic [7:0]            analog_ff;
  logic [7:0]            opMode_ff;
  logic [7:0]            vmode_ff;
  logic [7:0]            rdData_ff;
  logic                  rdValid_ff;

  logic       strapDone;
  logic       strapTake;
  logic       anyAccess;
  logic       wrEn;
  logic       hitIdLow;
  logic       hitIdHigh;
  logic       hitPwr;
  logic       hitCap;
  logic       hitRevLow;
  logic       hitRevHigh;
  logic       hitSrc;
  logic       hitAnalog;
  logic       hitOpMode;
  logic       hitVmode;
  logic       wrIdLow;
  logic       wrIdHigh;
  logic [1:0] pwrCode;
  logic [7:0] readMux;

  // Address decode.
  assign hitIdLow   = hit(hostReq.addr, dirc_pkg::OFF_ID_LOW);
  assign hitIdHigh  = hit(hostReq.addr, dirc_pkg::OFF_ID_HIGH);
  assign hitPwr     = hit(hostReq.addr, dirc_pkg::OFF_PWR_STATE);
  assign hitCap     = hit(hostReq.addr, dirc_pkg::OFF_PWR_CAP);
  assign hitRevLow  = hit(hostReq.addr, dirc_pkg::OFF_REV_LOW);
  assign hitRevHigh = hit(hostReq.addr, dirc_pkg::OFF_REV_HIGH);
  assign hitSrc     = hit(hostReq.addr, dirc_pkg::OFF_SRC_SEL);
  assign hitAnalog  = hit(hostReq.addr, dirc_pkg::OFF_ANALOG);
  assign hitOpMode  = hit(hostReq.addr, dirc_pkg::OFF_OPMODE);
  assign hitVmode   = hit(hostReq.addr, dirc_pkg::OFF_VMODE);

  assign wrEn      = hostReq.wr;
  assign anyAccess = hostReq.wr || hostReq.rd;

  // Strap capture; accesses to the identifier before it are ignored so the straps cannot be lost.
  assign strapTake = (startCnt_ff == dirc_pkg::STRAP_WAIT);
  assign strapDone = (startCnt_ff == dirc_pkg::STRAP_DONE);
  assign wrIdLow   = wrEn && hitIdLow && strapDone && !lockLow_ff; // R3
  assign wrIdHigh  = wrEn && hitIdHigh && strapDone && !lockHigh_ff; // R3

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strapSync1_ff <= '0;
      strapSync2_ff <= '0;
      startCnt_ff   <= 2'h0;
    end else begin
      strapSync1_ff <= strapPins;
      strapSync2_ff <= strapSync1_ff;
      startCnt_ff   <= strapDone ? startCnt_ff : startCnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idLow_ff <= 8'h00;
    end else if (strapTake) begin
      idLow_ff <= strapSync2_ff.dataPins; // R1
    end else if (wrIdLow) begin
      idLow_ff <= hostReq.data; // R3
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idHigh_ff <= 8'h00;
    end else if (strapTake) begin
      idHigh_ff <= {strapSync2_ff.addrPins, strapSync2_ff.vertical_sync_pin, // R2
                    strapSync2_ff.horizontal_sync_pin, strapSync2_ff.lumaOutHigh, strapSync2_ff.chromaOutHigh};
    end else if (wrIdHigh) begin
      idHigh_ff <= hostReq.data; // R3
    end
  end

  // Any read or write of an identifier byte after the strap capture locks that byte until reset.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lockLow_ff  <= 1'b0;
      lockHigh_ff <= 1'b0;
    end else begin
      lockLow_ff  <= lockLow_ff || (anyAccess && hitIdLow && strapDone); // R4
      lockHigh_ff <= lockHigh_ff || (anyAccess && hitIdHigh && strapDone); // R4
    end
  end

  // Only the two implemented codes move the state; the others leave it as it is.
  assign pwrCode = hostReq.data[1:0];
  always_comb begin
    nxt_pwr = pwr_ff;
    if (wrEn && hitPwr) begin
      if (pwrCode == dirc_pkg::PWR_CODE_FULL) begin
        nxt_pwr = dirc_pkg::PWR_FULL; // R8 R6
      end else if (pwrCode == dirc_pkg::PWR_CODE_LOWEST) begin
        nxt_pwr = dirc_pkg::PWR_LOWEST; // R8 R6
      end else begin
        nxt_pwr = pwr_ff; // R9 R7
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_ff    <= dirc_pkg::PWR_FULL; // R6
      srcSel_ff <= dirc_pkg::RST_SRC_SEL;
      analog_ff <= dirc_pkg::RST_ANALOG;
      opMode_ff <= dirc_pkg::RST_OPMODE;
      vmode_ff  <= dirc_pkg::RST_VMODE;
    end else begin
      pwr_ff    <= nxt_pwr;
      srcSel_ff <= (wrEn && hitSrc) ? hostReq.data : srcSel_ff;
      analog_ff <= (wrEn && hitAnalog) ? hostReq.data : analog_ff;
      opMode_ff <= (wrEn && hitOpMode) ? hostReq.data : opMode_ff;
      vmode_ff  <= (wrEn && hitVmode) ? hostReq.data : vmode_ff;
    end
  end

  // Read path; unmapped addresses read as zero.
  assign readMux = hitIdLow   ? idLow_ff :
                   hitIdHigh  ? idHigh_ff :
                   hitPwr     ? {6'h00, (pwr_ff == dirc_pkg::PWR_LOWEST) ? dirc_pkg::PWR_CODE_LOWEST // R5
                                                                       : dirc_pkg::PWR_CODE_FULL} :
                   hitCap     ? dirc_pkg::PWR_CAP_VAL : // R10
                   hitRevLow  ? dirc_pkg::REV_ID[7:0] : // R11
                   hitRevHigh ? dirc_pkg::REV_ID[15:8] : // R11
                   hitSrc     ? srcSel_ff :
                   hitAnalog  ? analog_ff :
                   hitOpMode  ? opMode_ff :
                   hitVmode   ? vmode_ff : dirc_pkg::RD_ZERO;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData_ff  <= 8'h00;
      rdValid_ff <= 1'b0;
    end else begin
      rdData_ff  <= hostReq.rd ? readMux : rdData_ff;
      rdValid_ff <= hostReq.rd;
    end
  end

  assign rdData  = rdData_ff;
  assign rdValid = rdValid_ff;

  // Either the power state or the power-down bit shuts the converters and slows the clocks.
  assign adcOff       = (pwr_ff == dirc_pkg::PWR_LOWEST) || opMode_ff[dirc_pkg::PDOWN_BIT]; // R6 R24
  assign clockMinimum = adcOff; // R6 R24
  assign oscFreeze    = opMode_ff[dirc_pkg::OSC_BIT]; // R23

  assign videoMode = dirc_pkg::dirc_vmode_t'(vmode_ff[1:0]); // R14
  assign route     = '{chanOneFromB:  srcSel_ff[dirc_pkg::SRC_CH1_BIT], // R12
                       chanTwoFromB:  srcSel_ff[dirc_pkg::SRC_CH2_BIT], // R13
                       lumaOnTwo:     videoMode inside {dirc_pkg::VM_COMP_TWO, dirc_pkg::VM_YC_TWO_ONE}, // R14
                       chromaPresent: videoMode inside {dirc_pkg::VM_YC_ONE_TWO, dirc_pkg::VM_YC_TWO_ONE}}; // R14

  assign offsetModeTwo = ctlMode(analog_ff[dirc_pkg::OFS2_LSB +: 2]); // R15
  assign offsetModeOne = ctlMode(analog_ff[dirc_pkg::OFS1_LSB +: 2]); // R16
  assign gainMode      = ctlMode(analog_ff[dirc_pkg::GAIN_LSB +: 2]); // R17

  dirc_filter_mode u_filter_mode (
    .clock        (clock),
    .arst_n       (arst_n),
    .mode         (dirc_pkg::dirc_tvvcr_t'(opMode_ff[dirc_pkg::TVVCR_LSB +: 2])), // R18 R20
    .palStandard  (palStandard),
    .syncUnstable (syncUnstable),
    .filterOvr    (filterOvr),
    .vcrActive    (vcrActive)
  );

  a_strap_low: assert property (@(posedge clock) disable iff (!arst_n) // R1
    strapTake |=> (idLow_ff == $past(strapSync2_ff.dataPins)))
    else $error("identifier low byte did not take the data strap pins");

  a_strap_high: assert property (@(posedge clock) disable iff (!arst_n) // R2
    strapTake |=> (idHigh_ff[7:6] == $past(strapSync2_ff.addrPins)
      && idHigh_ff[1:0] == $past(strapSync2_ff.chromaOutHigh)))
    else $error("identifier high byte did not take its strap pins");

  a_id_first_write: assert property (@(posedge clock) disable iff (!arst_n) // R3
    (strapDone && !lockLow_ff && wrEn && hitIdLow) |=> (idLow_ff == $past(hostReq.data) && lockLow_ff))
    else $error("first identifier write was not stored");

  a_id_lock_hold: assert property (@(posedge clock) disable iff (!arst_n) // R4
    (lockHigh_ff && wrEn && hitIdHigh) |=> $stable(idHigh_ff))
    else $error("locked identifier changed on a write");

  a_pwr_read_zero: assert property (@(posedge clock) disable iff (!arst_n) // R5
    (hostReq.rd && !hostReq.wr && hitPwr) |=> (rdValid && rdData[7:2] == 6'h00))
    else $error("power state read showed nonzero upper bits");

  a_pwr_lowest: assert property (@(posedge clock) disable iff (!arst_n) // R8
    (wrEn && hitPwr && pwrCode == dirc_pkg::PWR_CODE_LOWEST) |=> (adcOff && clockMinimum))
    else $error("writing the lowest power code did not shut the converters");

  a_pwr_bad_code: assert property (@(posedge clock) disable iff (!arst_n) // R9
    (wrEn && hitPwr && (pwrCode == 2'h1 || pwrCode == 2'h2)) |=> $stable(pwr_ff))
    else $error("unsupported power code changed the power state");

  a_cap_read: assert property (@(posedge clock) disable iff (!arst_n) // R10
    (hostReq.rd && hitCap) |=> (rdValid && rdData == 8'h00))
    else $error("power capability did not read as zero");

  a_rev_high: assert property (@(posedge clock) disable iff (!arst_n) // R11
    (hostReq.rd && hitRevHigh) |=> (rdData == dirc_pkg::REV_ID[15:8]))
    else $error("revision high byte read wrong");

  a_pdown_bit: assert property (@(posedge clock) disable iff (!arst_n) // R24
    (wrEn && hitOpMode && hostReq.data[0]) |=> adcOff)
    else $error("power-down bit did not shut the converters");

endmodule // dirc_regs

// ### hw/dirc_pkg.sv
// Purpose: Shared constants, types and field layouts of the decoder id, power and input control registers.
// Assumes: Eight-bit host data and sixteen-bit host port addresses.
// Notes:   Every offset, timing count and control register reset lives here; the power code and video mode fields sit at bits 1:0 in dirc_regs.
package dirc_pkg;

  localparam int ADDR_W = 16;

  // Register byte addresses on the host port.
  localparam logic [ADDR_W-1:0] OFF_ID_LOW    = 16'h0006;
  localparam logic [ADDR_W-1:0] OFF_ID_HIGH   = 16'h0007;
  localparam logic [ADDR_W-1:0] OFF_PWR_STATE = 16'h0008;
  localparam logic [ADDR_W-1:0] OFF_PWR_CAP   = 16'h000a;
  localparam logic [ADDR_W-1:0] OFF_REV_LOW   = 16'h000c;
  localparam logic [ADDR_W-1:0] OFF_REV_HIGH  = 16'h000d;
  localparam logic [ADDR_W-1:0] OFF_SRC_SEL   = 16'h0100;
  localparam logic [ADDR_W-1:0] OFF_ANALOG    = 16'h0101;
  localparam logic [ADDR_W-1:0] OFF_OPMODE    = 16'h0102;
  localparam logic [ADDR_W-1:0] OFF_VMODE     = 16'h0120;

  // Reset values and fixed read values.
  localparam logic [7:0] RST_SRC_SEL = 8'h00;
  localparam logic [7:0] RST_ANALOG  = 8'h15;
  localparam logic [7:0] RST_OPMODE  = 8'h00;
  localparam logic [7:0] RST_VMODE   = 8'h00;
  localparam logic [7:0] PWR_CAP_VAL = 8'h00;
  localparam logic [7:0] RD_ZERO     = 8'h00;

  // Revision identifier; the value is arbitrary.
  localparam logic [15:0] REV_ID = 16'h0203;

  // Field positions.
  localparam int SRC_CH1_BIT = 1;
  localparam int SRC_CH2_BIT = 0;
  localparam int OFS2_LSB    = 4;
  localparam int OFS1_LSB    = 2;
  localparam int GAIN_LSB    = 0;
  localparam int TVVCR_LSB   = 4;
  localparam int OSC_BIT     = 2;
  localparam int PDOWN_BIT   = 0;

  // Power state codes.
  localparam logic [1:0] PWR_CODE_FULL   = 2'h0;
  localparam logic [1:0] PWR_CODE_LOWEST = 2'h3;

  // Strap sampling: edges after reset release until the synchroniser output is valid.
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  typedef enum logic [1:0] {PWR_FULL, PWR_LOWEST} dirc_pwr_t;
  typedef enum logic [1:0] {OFS_DISABLED, OFS_ENABLED, OFS_RESERVED, OFS_FROZEN} dirc_ctl_mode_t;
  typedef enum logic [1:0] {TVM_AUTO, TVM_MANUAL, TVM_VCR, TVM_TV} dirc_tvvcr_t;
  typedef enum logic [1:0] {VM_COMP_ONE, VM_YC_TWO_ONE, VM_YC_ONE_TWO, VM_COMP_TWO} dirc_vmode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } dirc_host_req_t;

  typedef struct packed {
    logic [7:0] dataPins;
    logic [1:0] addrPins;
    logic       vertical_sync_pin;
    logic       horizontal_sync_pin;
    logic [1:0] lumaOutHigh;
    logic [1:0] chromaOutHigh;
  } dirc_strap_t;

  typedef struct packed {
    logic chanOneFromB;
    logic chanTwoFromB;
    logic lumaOnTwo;
    logic chromaPresent;
  } dirc_route_t;

  typedef struct packed {
    logic       apply;
    logic       adaptive_comb_enable;
    logic       chromaCombEnable;
    logic [2:0] chromaCombModeMask;
    logic [2:0] chroma_comb_mode;
    logic       luma_filter_select_bit;
    logic [1:0] chroma_filter_select;
    logic [1:0] luma_filter_field;
  } dirc_filter_ovr_t;

endpackage

// ### hw/dirc_filter_mode.sv
// Purpose: Turns the TV/VCR mode and sync detection into filter field overrides.
// Assumes: Detection and standard inputs come from logic on the same clock.
// Notes:   Fields the table leaves unchanged are reported through the mode mask.
module dirc_filter_mode (
  // Clock and reset.
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  // Mode and detection.
  input  wire dirc_pkg::dirc_tvvcr_t      mode,
  input  wire logic                       palStandard,
  input  wire logic                       syncUnstable,
  // Overrides.
  output      dirc_pkg::dirc_filter_ovr_t filterOvr,
  output      logic                       vcrActive
);

  dirc_pkg::dirc_filter_ovr_t filterOvr_ff;
  dirc_pkg::dirc_filter_ovr_t nxt_filterOvr;
  logic                       vcrActive_ff;
  logic                       wantVcr;
  logic                       wantApply;

  assign wantVcr   = (mode == dirc_pkg::TVM_VCR) || (mode == dirc_pkg::TVM_AUTO && syncUnstable); // R19 R21
  assign wantApply = (mode != dirc_pkg::TVM_MANUAL); // R18

  always_comb begin
    nxt_filterOvr = '0;
    nxt_filterOvr.apply = wantApply;
    if (wantVcr) begin
      nxt_filterOvr.adaptive_comb_enable   = 1'b0; // R21
      nxt_filterOvr.chromaCombEnable       = palStandard;
      nxt_filterOvr.chromaCombModeMask     = palStandard ? 3'h4 : 3'h0;
      nxt_filterOvr.chroma_comb_mode       = palStandard ? 3'h4 : 3'h0;
      nxt_filterOvr.luma_filter_select_bit = 1'b1;
      nxt_filterOvr.chroma_filter_select   = palStandard ? 2'h1 : 2'h2;
      nxt_filterOvr.luma_filter_field      = 2'h3;
    end else begin
      nxt_filterOvr.adaptive_comb_enable   = 1'b1; // R22 R20
      nxt_filterOvr.chromaCombEnable       = 1'b1;
      nxt_filterOvr.chromaCombModeMask     = 3'h7;
      nxt_filterOvr.chroma_comb_mode       = 3'h0;
      nxt_filterOvr.luma_filter_select_bit = 1'b0;
      nxt_filterOvr.chroma_filter_select   = 2'h0;
      nxt_filterOvr.luma_filter_field      = 2'h0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      filterOvr_ff <= '0;
      vcrActive_ff <= 1'b0;
    end else begin
      filterOvr_ff <= nxt_filterOvr;
      vcrActive_ff <= wantVcr && wantApply;
    end
  end

  assign filterOvr = filterOvr_ff;
  assign vcrActive = vcrActive_ff;

  a_tv_forced: assert property (@(posedge clock) disable iff (!arst_n) // R22
    (mode == dirc_pkg::TVM_TV) |=> (filterOvr.apply && filterOvr.adaptive_comb_enable
      && filterOvr.chroma_comb_mode == 3'h0 && !filterOvr.luma_filter_select_bit))
    else $error("forced standard mode did not apply standard filter values");

  a_vcr_forced: assert property (@(posedge clock) disable iff (!arst_n) // R21
    (mode == dirc_pkg::TVM_VCR) |=> (vcrActive && !filterOvr.adaptive_comb_enable
      && filterOvr.luma_filter_field == 2'h3))
    else $error("forced nonstandard mode did not apply its filter values");

  a_auto_switch: assert property (@(posedge clock) disable iff (!arst_n) // R19
    (mode == dirc_pkg::TVM_AUTO && syncUnstable) |=> (vcrActive && filterOvr.luma_filter_select_bit))
    else $error("unstable syncs in automatic mode did not select nonstandard handling");

endmodule // dirc_filter_mode

// ### testbench/dirc_host_model.sv
// Purpose: Host controller model driving the register port of the decoder.
// Assumes: One request at a time, launched by non-blocking assignment at a rising edge.
// Notes:   Each request is held for exactly one cycle, as the port takes it on one edge.
module dirc_host_model (
  // Clock.
  input  wire logic                     clock,
  // Register port.
  output      dirc_pkg::dirc_host_req_t hostReq,
  input  wire logic [7:0]               rdData,
  input  wire logic                     rdValid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial hostReq = '0;

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    hostReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clock);
    hostReq <= '0;
  endtask

  // The port holds read data until the next read but shows its valid flag only until the edge after the taking edge,
  // so both are sampled just after the taking edge.
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    hostReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge clock);
    hostReq <= '0;
    #1;
    v = rdValid;
    d = rdData;
  endtask
endmodule // dirc_host_model

// ### testbench/tb.sv
// Purpose: Self-checking bench for the identifier, power and input control registers.
// Assumes: Strap pins stay stable from reset release until well after the capture edge.
// Notes:   Filter overrides are compared as one packed word built from the mode tables.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                       clock;
  logic                       arst_n;
  logic                       palStandard;
  logic                       syncUnstable;
  logic [7:0]                 rdData;
  logic                       rdValid;
  logic                       adcOff;
  logic                       clockMinimum;
  logic                       oscFreeze;
  logic                       vcrActive;
  dirc_pkg::dirc_host_req_t   hostReq;
  dirc_pkg::dirc_strap_t      strapPins;
  dirc_pkg::dirc_route_t      route;
  dirc_pkg::dirc_vmode_t      videoMode;
  dirc_pkg::dirc_ctl_mode_t   offsetModeOne;
  dirc_pkg::dirc_ctl_mode_t   offsetModeTwo;
  dirc_pkg::dirc_ctl_mode_t   gainMode;
  dirc_pkg::dirc_filter_ovr_t filterOvr;
  int                         n_fail = 0;
  int                         n_tests = 0;

  dirc_regs uut (.clock(clock), .arst_n(arst_n), .hostReq(hostReq), .rdData(rdData), .rdValid(rdValid),
    .strapPins(strapPins), .palStandard(palStandard), .syncUnstable(syncUnstable), .adcOff(adcOff),
    .clockMinimum(clockMinimum), .oscFreeze(oscFreeze), .route(route), .videoMode(videoMode),
    .offsetModeOne(offsetModeOne), .offsetModeTwo(offsetModeTwo), .gainMode(gainMode),
    .filterOvr(filterOvr), .vcrActive(vcrActive));

  dirc_host_model host (.clock(clock), .hostReq(hostReq), .rdData(rdData), .rdValid(rdValid));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk("rdValid", 16'(v), 16'h0001);
    chk($sformatf("rdData at %h", a), 16'(d), 16'(exp));
  endtask

  // The host may not touch the identifier before the capture edge, hence the wait.
  task automatic do_reset(input logic [15:0] s);
    @(posedge clock);
    strapPins <= s;
    arst_n <= 1'b0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  task automatic test_ident();
    do_reset(16'h5aa5);
    rchk(dirc_pkg::OFF_ID_LOW, 8'h5a);
    host.wr(dirc_pkg::OFF_ID_LOW, 8'h33);
    rchk(dirc_pkg::OFF_ID_LOW, 8'h5a);
    rchk(dirc_pkg::OFF_ID_HIGH, 8'ha5);
    do_reset(16'hc36e);
    host.wr(dirc_pkg::OFF_ID_HIGH, 8'h77);
    rchk(dirc_pkg::OFF_ID_HIGH, 8'h77);
    host.wr(dirc_pkg::OFF_ID_HIGH, 8'h11);
    rchk(dirc_pkg::OFF_ID_HIGH, 8'h77);
    rchk(dirc_pkg::OFF_ID_LOW, 8'hc3);
    do_reset(16'h5aa5);
    host.wr(dirc_pkg::OFF_ID_LOW, 8'h44);
    rchk(dirc_pkg::OFF_ID_LOW, 8'h44);
    $display("test_ident done");
  endtask

  task automatic test_power();
    rchk(dirc_pkg::OFF_PWR_STATE, 8'h00);
    host.wr(dirc_pkg::OFF_PWR_STATE, 8'hff);
    #1;
    chk("adcOff", 16'(adcOff), 16'h0001);
    chk("clockMinimum", 16'(clockMinimum), 16'h0001);
    rchk(dirc_pkg::OFF_PWR_STATE, 8'h03);
    host.wr(dirc_pkg::OFF_PWR_STATE, 8'h01);
    rchk(dirc_pkg::OFF_PWR_STATE, 8'h03);
    host.wr(dirc_pkg::OFF_PWR_STATE, 8'h02);
    rchk(dirc_pkg::OFF_PWR_STATE, 8'h03);
    host.wr(dirc_pkg::OFF_PWR_STATE, 8'h00);
    #1;
    chk("adcOff", 16'(adcOff), 16'h0000);
    host.wr(dirc_pkg::OFF_PWR_CAP, 8'hff);
    rchk(dirc_pkg::OFF_PWR_CAP, 8'h00);
    host.wr(dirc_pkg::OFF_REV_LOW, 8'h55);
    rchk(dirc_pkg::OFF_REV_LOW, dirc_pkg::REV_ID[7:0]);
    rchk(dirc_pkg::OFF_REV_HIGH, dirc_pkg::REV_ID[15:8]);
    rchk(16'h0200, 8'h00);
    $display("test_power done");
  endtask

  task automatic test_ctrl();
    rchk(dirc_pkg::OFF_SRC_SEL, 8'h00);
    rchk(dirc_pkg::OFF_ANALOG, 8'h15);
    rchk(dirc_pkg::OFF_OPMODE, 8'h00);
    for (int c = 0; c < 4; c++) begin
      host.wr(dirc_pkg::OFF_SRC_SEL, 8'(c));
      host.wr(dirc_pkg::OFF_ANALOG, 8'(c * 21));
      host.wr(dirc_pkg::OFF_VMODE, 8'(c));
      #1;
      chk("chanOneFromB", 16'(route.chanOneFromB), 16'(c[1]));
      chk("chanTwoFromB", 16'(route.chanTwoFromB), 16'(c[0]));
      chk("offsetModeTwo", 16'(offsetModeTwo), 16'(c));
      chk("offsetModeOne", 16'(offsetModeOne), 16'(c));
      chk("gainMode", 16'(gainMode), 16'(c));
      chk("videoMode", 16'(videoMode), 16'(c));
      chk("lumaOnTwo", 16'(route.lumaOnTwo), 16'(c[0]));
      chk("chromaPresent", 16'(route.chromaPresent), 16'(c[0] ^ c[1]));
    end
    host.wr(dirc_pkg::OFF_OPMODE, 8'h05);
    #1;
    chk("oscFreeze", 16'(oscFreeze), 16'h0001);
    chk("adcOff", 16'(adcOff), 16'h0001);
    host.wr(dirc_pkg::OFF_OPMODE, 8'h00);
    #1;
    chk("oscFreeze", 16'(oscFreeze), 16'h0000);
    chk("adcOff", 16'(adcOff), 16'h0000);
    $display("test_ctrl done");
  endtask

  task automatic fchk(input logic [7:0] m, input logic pal, input logic unst, input logic [13:0] exp,
                      input logic vcr);
    @(posedge clock);
    palStandard <= pal;
    syncUnstable <= unst;
    host.wr(dirc_pkg::OFF_OPMODE, m);
    repeat (2) @(posedge clock);
    #1;
    chk("filterOvr", 16'(filterOvr), 16'(exp));
    chk("vcrActive", 16'(vcrActive), 16'(vcr));
  endtask

  task automatic test_filter();
    fchk(8'h30, 1'b0, 1'b1, 14'h3f00, 1'b0);
    fchk(8'h20, 1'b0, 1'b0, 14'h201b, 1'b1);
    fchk(8'h20, 1'b1, 1'b0, 14'h2c97, 1'b1);
    fchk(8'h00, 1'b1, 1'b1, 14'h2c97, 1'b1);
    fchk(8'h00, 1'b1, 1'b0, 14'h3f00, 1'b0);
    fchk(8'h00, 1'b0, 1'b1, 14'h201b, 1'b1);
    host.wr(dirc_pkg::OFF_OPMODE, 8'h10);
    repeat (2) @(posedge clock);
    #1;
    chk("filterOvr.apply", 16'(filterOvr.apply), 16'h0000);
    $display("test_filter done");
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // About one hundred fifty cycles are expected; the limit leaves wide margin.
  initial begin
    #(40 * 6000);
    n_fail++;
    finish_test();
  end

  initial begin
    arst_n = 1'b0;
    palStandard = 1'b0;
    syncUnstable = 1'b0;
    strapPins = 16'h5aa5;
    test_ident();
    test_power();
    test_ctrl();
    test_filter();
    finish_test();
  end
endmodule // tb
